// File: verilog/osc_params.svh
// Offsets, field positions, mode codes and timing figures of the oscillator block
`ifndef OSC_PARAMS_SVH
`define OSC_PARAMS_SVH

// Register map (byte addresses on the plain register port)
`define OSC_ADDR_W 8
`define OSC_TRIM_ADDR 8'h90
`define OSC_CTRL_ADDR 8'h94
`define OSC_TRIM_RESET 6'h00
`define OSC_FSEL_RESET 3'h0
`define OSC_SRC_RESET 2'h0

// Control register fields
`define OSC_FSEL_LSB 4
`define OSC_FSEL_MSB 6
`define OSC_PRIMARY_BIT 3
`define OSC_SRC_LSB 0
`define OSC_SRC_MSB 1

// Configuration codes of the eight primary modes
`define OSC_MODE_LOW_POWER_CRYSTAL 3'h0
`define OSC_MODE_CRYSTAL_RESONATOR 3'h1
`define OSC_MODE_HIGH_SPEED_CRYSTAL 3'h2
`define OSC_MODE_EXTERNAL_CLOCK_IO 3'h3
`define OSC_MODE_INTERNAL_IO 3'h4
`define OSC_MODE_INTERNAL_CLKOUT 3'h5
`define OSC_MODE_EXTERNAL_RC_IO 3'h6
`define OSC_MODE_EXTERNAL_RC_CLKOUT 3'h7

// Frequency select and source select codes
`define OSC_FSEL_SLOW_RC 3'h0
`define OSC_FSEL_FAST_DIRECT 3'h7
`define OSC_SRC_PRIMARY 2'h0
`define OSC_SRC_TIMER1 2'h1
`define OSC_SRC_INTERNAL 2'h2

// Oscillator models: 24-bit phase accumulators on the 125 MHz clock
`define OSC_ACC_W 24
`define OSC_FAST_INC 24'h10624e
`define OSC_SLOW_INC 24'h001062
`define OSC_POST_W 7
`define OSC_POST_TAPS 6

// Timing
`define OSC_MCLK_MHZ 125
`define OSC_TRIM_STEPS 64
`define OSC_FAST_SETTLE_NS 1000000
`define OSC_FAST_SETTLE_CYC (`OSC_FAST_SETTLE_NS * `OSC_MCLK_MHZ / 1000)
`define OSC_SLOW_SETTLE_TICKS 8

`endif

// File: verilog/osc_pkg.sv
// Types shared by the oscillator block
package osc_pkg;
  `include "osc_params.svh"

  typedef enum logic [2:0] {
    LOW_POWER_CRYSTAL_MODE = `OSC_MODE_LOW_POWER_CRYSTAL,
    CRYSTAL_RESONATOR_MODE = `OSC_MODE_CRYSTAL_RESONATOR,
    HIGH_SPEED_CRYSTAL_MODE = `OSC_MODE_HIGH_SPEED_CRYSTAL,
    EXTERNAL_CLOCK_IO_MODE = `OSC_MODE_EXTERNAL_CLOCK_IO,
    INTERNAL_OSC_IO_MODE = `OSC_MODE_INTERNAL_IO,
    INTERNAL_OSC_CLKOUT_MODE = `OSC_MODE_INTERNAL_CLKOUT,
    EXTERNAL_RC_MODE_IO = `OSC_MODE_EXTERNAL_RC_IO,
    EXTERNAL_RC_MODE_CLKOUT = `OSC_MODE_EXTERNAL_RC_CLKOUT
  } osc_mode_t;

  typedef struct packed {
    logic power_up_timer;
    logic watchdog;
    logic two_speed;
    logic fail_safe;
  } slow_rc_users_t;

  typedef struct packed {
    logic drive;
    logic oe;
  } pin_drive_t;
endpackage : osc_pkg

// File: verilog/trim_nco.sv
// Phase-accumulator oscillator model whose rate is scaled by a signed trim code
`timescale 1ns/1ps
module trim_nco #(
  parameter int ACC_W = 24,
  parameter logic [ACC_W-1:0] BASE_INC = '0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Trim code, two's complement
  input wire logic signed [5:0] trim_in,
  // One pulse per oscillator period
  output logic tick_out
);
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W:0] sum;
  logic signed [31:0] base_s;
  logic signed [31:0] trim_s;
  logic signed [31:0] prod;
  logic signed [31:0] inc_s;

  // Rate = base * (256 + trim) / 256, so each code is an equal step of 1/256
  assign base_s = $signed({{(32 - ACC_W){1'b0}}, BASE_INC});
  assign trim_s = 32'(trim_in);
  assign prod = base_s * trim_s;
  assign inc_s = base_s + (prod >>> 8);
  assign sum = {1'b0, acc_q} + {1'b0, inc_s[ACC_W-1:0]};

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      acc_q <= '0;
      tick_out <= 1'b0;
    end else begin
      acc_q <= sum[ACC_W-1:0];
      tick_out <= sum[ACC_W];
    end
  end
endmodule : trim_nco

// File: verilog/osc_config.sv
// Oscillator mode, pin assignment, internal oscillator block and trim register
//
// How it works
// - Eight primary oscillator modes, chosen by a three-bit configuration code.
// - Crystal modes keep both oscillator pins off the port.
// - External clock mode takes edges from the input pin, no start-up delay.
// - External clock mode turns the output pin into port bit six.
// - External RC with clock out drives oscillator frequency divided by four.
// - External RC I/O mode is the same but output pin is port bit six.
// - Fast internal oscillator gives 8 MHz and six postscaled rates.
// - Slow internal RC gives 31.25 kHz, 32 us period.
// - Slow RC runs when selected or any dependent timer feature is enabled.
// - Frequency select picks fast direct, slow direct or a postscaler output.
// - Internal clock-out mode drives sysclk/4, input pin is port bit seven.
// - Internal I/O mode gives both pins to port bits six and seven.
// - Trim scales frequency in equal steps from minus 12.5 to plus 12.1 percent.
// - Slow RC retunes within 8 of its cycles, fast within 1 ms.
// - No flag reports that a trim change has settled.
// - Trim is six-bit two's complement, zero is centre frequency.
// - Trim also shifts the timebase handed to slow-RC users.
// - Frequency codes 000 slow RC, 001-110 postscaler, 111 8 MHz.
// - Source select 00 primary, 01 Timer1, 10 internal block, 11 also primary.
// - Primary mode is captured once after reset and then held.
`timescale 1ns/1ps
`include "osc_params.svh"
module osc_config
  #(
  parameter int SETTLE_CYCLES = `OSC_FAST_SETTLE_CYC
) (
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic RST_B_IN,
  // Configuration word and feature enables
  input wire logic [2:0] CFG_MODE_IN,
  input wire osc_pkg::slow_rc_users_t SLOW_USERS_IN,
  // Register port
  input wire logic [`OSC_ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  // Oscillator pins
  input wire logic OSC_IN_PIN_IN,
  output logic OSC_IN_PIN_OUT,
  output logic OSC_IN_PIN_OE_OUT,
  input wire logic OSC_OUT_PIN_IN,
  output logic OSC_OUT_PIN_OUT,
  output logic OSC_OUT_PIN_OE_OUT,
  // Port logic for bits six and seven
  input wire osc_pkg::pin_drive_t PORT_BIT6_IN,
  input wire osc_pkg::pin_drive_t PORT_BIT7_IN,
  output logic PORT_BIT6_PIN_OUT,
  output logic PORT_BIT7_PIN_OUT,
  output logic PORT_BIT6_IS_IO_OUT,
  output logic PORT_BIT7_IS_IO_OUT,
  // Clock sources and results
  input wire logic TIMER1_TICK_IN,
  output logic SYSCLK_TICK_OUT,
  output logic SLOW_RC_TICK_OUT,
  output logic SLOW_RC_RUN_OUT,
  output logic STARTUP_DELAY_OUT,
  output logic [2:0] MODE_OUT
);
  import osc_pkg::*;

  localparam int STEP_CYCLES = SETTLE_CYCLES / `OSC_TRIM_STEPS;

  // Register state
  osc_mode_t mode_q;
  logic cfg_taken_q;
  logic signed [5:0] trim_q;
  logic [2:0] fsel_q;
  logic [1:0] src_q;
  logic [7:0] rdata_d;

  // Trim as seen by each oscillator
  logic signed [5:0] fast_trim_q;
  logic signed [5:0] slow_trim_q;
  logic [31:0] step_cnt_q;

  // Clock ticks
  logic fast_tick;
  logic slow_tick;
  logic [`OSC_POST_W-1:0] post_q;
  logic slow_selected;
  logic [`OSC_POST_TAPS:0] post_tick;
  logic int_tick;
  logic osc_in_prev_q;
  logic ext_tick;
  logic primary_tick;
  logic sys_tick;
  logic [1:0] div4_q;

  // Mode decode
  logic is_crystal;
  logic is_internal;
  logic bit6_io;
  logic bit7_io;
  logic clkout_on;
  logic wr_trim;
  logic wr_ctrl;
  logic primary_run;
  pin_drive_t out_pin_d;
  pin_drive_t in_pin_d;

  function automatic logic crystal_mode(input osc_mode_t m);
    crystal_mode = (m == LOW_POWER_CRYSTAL_MODE) || (m == CRYSTAL_RESONATOR_MODE) ||
                   (m == HIGH_SPEED_CRYSTAL_MODE);
  endfunction : crystal_mode

  function automatic logic internal_mode(input osc_mode_t m);
    internal_mode = (m == INTERNAL_OSC_IO_MODE) || (m == INTERNAL_OSC_CLKOUT_MODE);
  endfunction : internal_mode

  // Primary mode captured once after reset release
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      cfg_taken_q <= 1'b0;
      mode_q <= LOW_POWER_CRYSTAL_MODE;
    end else if (!cfg_taken_q) begin
      cfg_taken_q <= 1'b1;
      mode_q <= osc_mode_t'(CFG_MODE_IN);
    end
  end

  // Register writes
  assign wr_trim = REG_WR_IN && (REG_ADDR_IN == `OSC_TRIM_ADDR);
  assign wr_ctrl = REG_WR_IN && (REG_ADDR_IN == `OSC_CTRL_ADDR);

  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      trim_q <= `OSC_TRIM_RESET;
      fsel_q <= `OSC_FSEL_RESET;
      src_q <= `OSC_SRC_RESET;
    end else begin
      if (wr_trim) begin
        trim_q <= REG_WDATA_IN[5:0];
      end
      if (wr_ctrl) begin
        fsel_q <= REG_WDATA_IN[`OSC_FSEL_MSB:`OSC_FSEL_LSB];
        src_q <= REG_WDATA_IN[`OSC_SRC_MSB:`OSC_SRC_LSB];
      end
    end
  end

  // Readback; trim register holds no settle flag
  assign primary_run = (src_q == `OSC_SRC_PRIMARY) || (src_q == 2'h3);
  always_comb begin
    rdata_d = 8'h00;
    if (REG_RD_IN && (REG_ADDR_IN == `OSC_TRIM_ADDR)) begin
      rdata_d = {2'h0, trim_q};
    end else if (REG_RD_IN && (REG_ADDR_IN == `OSC_CTRL_ADDR)) begin
      rdata_d[`OSC_FSEL_MSB:`OSC_FSEL_LSB] = fsel_q;
      rdata_d[`OSC_PRIMARY_BIT] = primary_run;
      rdata_d[`OSC_SRC_MSB:`OSC_SRC_LSB] = src_q;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      REG_RDATA_OUT <= 8'h00;
    end else begin
      REG_RDATA_OUT <= rdata_d;
    end
  end

  // Fast oscillator slews one trim code per step interval
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      fast_trim_q <= `OSC_TRIM_RESET;
      step_cnt_q <= '0;
    end else if (fast_trim_q == trim_q) begin
      step_cnt_q <= '0;
    end else if (step_cnt_q >= 32'(STEP_CYCLES - 1)) begin
      step_cnt_q <= '0;
      fast_trim_q <= (fast_trim_q < trim_q) ? fast_trim_q + 6'sd1 :
                     fast_trim_q - 6'sd1;
    end else begin
      step_cnt_q <= step_cnt_q + 32'd1;
    end
  end

  // Slow oscillator takes the new trim at its next period
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      slow_trim_q <= `OSC_TRIM_RESET;
    end else if (slow_tick) begin
      slow_trim_q <= trim_q;
    end
  end

  trim_nco #(
    .ACC_W(`OSC_ACC_W),
    .BASE_INC(`OSC_FAST_INC)
  ) fast_osc (
    .clk_in(MCLK_IN),
    .rst_b_in(RST_B_IN),
    .trim_in(fast_trim_q),
    .tick_out(fast_tick)
  );

  trim_nco #(
    .ACC_W(`OSC_ACC_W),
    .BASE_INC(`OSC_SLOW_INC)
  ) slow_osc (
    .clk_in(MCLK_IN),
    .rst_b_in(RST_B_IN),
    .trim_in(slow_trim_q),
    .tick_out(slow_tick)
  );

  // Postscaler: tap k divides 8 MHz by 2^(7-k)
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      post_q <= '0;
    end else if (fast_tick) begin
      post_q <= post_q + 7'h01;
    end
  end

  assign post_tick[0] = slow_tick;
  for (genvar k = 1; k <= `OSC_POST_TAPS; k++) begin : g_post
    assign post_tick[k] = fast_tick && (&post_q[`OSC_POST_TAPS-k:0]);
  end

  assign int_tick = (fsel_q == `OSC_FSEL_FAST_DIRECT) ? fast_tick :
                    post_tick[fsel_q];

  // Primary source: pin edges or the internal block
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      osc_in_prev_q <= 1'b0;
    end else begin
      osc_in_prev_q <= OSC_IN_PIN_IN;
    end
  end

  assign is_crystal = crystal_mode(mode_q);
  assign is_internal = internal_mode(mode_q);
  assign ext_tick = OSC_IN_PIN_IN && !osc_in_prev_q;
  assign primary_tick = is_internal ? int_tick : ext_tick;

  assign sys_tick = (src_q == `OSC_SRC_TIMER1) ? TIMER1_TICK_IN :
                    (src_q == `OSC_SRC_INTERNAL) ? int_tick : primary_tick;

  // Divide-by-four clock output from the system clock
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      div4_q <= 2'h0;
    end else if (sys_tick) begin
      div4_q <= div4_q + 2'h1;
    end
  end

  // Pin roles
  assign bit6_io = (mode_q == EXTERNAL_CLOCK_IO_MODE) || (mode_q == EXTERNAL_RC_MODE_IO) ||
                   (mode_q == INTERNAL_OSC_IO_MODE);
  assign bit7_io = is_internal;
  assign clkout_on = (mode_q == EXTERNAL_RC_MODE_CLKOUT) ||
                     (mode_q == INTERNAL_OSC_CLKOUT_MODE);

  assign out_pin_d = bit6_io ? PORT_BIT6_IN :
                     clkout_on ? pin_drive_t'{drive: div4_q[1], oe: 1'b1} :
                     pin_drive_t'{drive: 1'b0, oe: 1'b0};
  assign in_pin_d = bit7_io ? PORT_BIT7_IN :
                    pin_drive_t'{drive: 1'b0, oe: 1'b0};

  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      OSC_OUT_PIN_OUT <= 1'b0;
      OSC_OUT_PIN_OE_OUT <= 1'b0;
      OSC_IN_PIN_OUT <= 1'b0;
      OSC_IN_PIN_OE_OUT <= 1'b0;
      PORT_BIT6_PIN_OUT <= 1'b0;
      PORT_BIT7_PIN_OUT <= 1'b0;
      PORT_BIT6_IS_IO_OUT <= 1'b0;
      PORT_BIT7_IS_IO_OUT <= 1'b0;
    end else begin
      OSC_OUT_PIN_OUT <= out_pin_d.drive;
      OSC_OUT_PIN_OE_OUT <= out_pin_d.oe;
      OSC_IN_PIN_OUT <= in_pin_d.drive;
      OSC_IN_PIN_OE_OUT <= in_pin_d.oe;
      PORT_BIT6_PIN_OUT <= bit6_io && OSC_OUT_PIN_IN;
      PORT_BIT7_PIN_OUT <= bit7_io && OSC_IN_PIN_IN;
      PORT_BIT6_IS_IO_OUT <= bit6_io;
      PORT_BIT7_IS_IO_OUT <= bit7_io;
    end
  end

  // Slow RC is the system clock directly or through an internal primary mode
  assign slow_selected = (fsel_q == `OSC_FSEL_SLOW_RC) &&
                         ((src_q == `OSC_SRC_INTERNAL) || (is_internal && primary_run));

  // Clock results
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      SYSCLK_TICK_OUT <= 1'b0;
      SLOW_RC_TICK_OUT <= 1'b0;
      SLOW_RC_RUN_OUT <= 1'b0;
      STARTUP_DELAY_OUT <= 1'b0;
      MODE_OUT <= 3'h0;
    end else begin
      SYSCLK_TICK_OUT <= sys_tick;
      SLOW_RC_TICK_OUT <= slow_tick;
      SLOW_RC_RUN_OUT <= (|SLOW_USERS_IN) || slow_selected;
      STARTUP_DELAY_OUT <= is_crystal;
      MODE_OUT <= mode_q;
    end
  end

  // Checks
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RST_B_IN);

  logic [3:0] slow_wait_q;
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN || (slow_trim_q == trim_q)) begin
      slow_wait_q <= 4'h0;
    end else if (slow_tick && (slow_wait_q != 4'hf)) begin
      slow_wait_q <= slow_wait_q + 4'h1;
    end
  end

  a_mode_held: assert property (cfg_taken_q |=> $stable(mode_q))
    else $error("mode changed after capture");
  a_crystal_pins_free: assert property (cfg_taken_q && is_crystal |=>
    !OSC_OUT_PIN_OE_OUT && !OSC_IN_PIN_OE_OUT && !PORT_BIT6_IS_IO_OUT)
    else $error("crystal pins driven");
  a_ext_no_delay: assert property (cfg_taken_q && mode_q == EXTERNAL_CLOCK_IO_MODE
    |=> !STARTUP_DELAY_OUT)
    else $error("start-up delay in external clock mode");
  a_bit6_follows_port: assert property (cfg_taken_q && bit6_io |=>
    OSC_OUT_PIN_OE_OUT == $past(PORT_BIT6_IN.oe))
    else $error("output pin not following port bit six");
  a_clkout_drives: assert property (cfg_taken_q && clkout_on |=>
    OSC_OUT_PIN_OE_OUT && OSC_OUT_PIN_OUT == $past(div4_q[1]))
    else $error("divided clock missing");
  a_div4_on_tick: assert property ($changed(div4_q) |-> $past(sys_tick))
    else $error("divider moved without a clock tick");
  a_slow_retune: assert property (slow_wait_q < 4'(`OSC_SLOW_SETTLE_TICKS))
    else $error("slow oscillator late to retune");
  a_fast_select: assert property (src_q == `OSC_SRC_INTERNAL && fsel_q == 3'h7 |->
    sys_tick == fast_tick)
    else $error("fast direct not selected");
  a_slow_select: assert property (src_q == `OSC_SRC_INTERNAL && fsel_q == 3'h0 |->
    sys_tick == slow_tick)
    else $error("slow direct not selected");
  a_timer1_source: assert property (src_q == `OSC_SRC_TIMER1 |=>
    SYSCLK_TICK_OUT == $past(TIMER1_TICK_IN))
    else $error("timer1 source not used");
  a_slow_run: assert property (|SLOW_USERS_IN |=> SLOW_RC_RUN_OUT)
    else $error("slow oscillator stopped while needed");
endmodule : osc_config

// File: testbench/osc_source_model.sv
// Behavioural external clock source on the oscillator input pin
`timescale 1ns/1ps
module osc_source_model #(
  parameter realtime HALF_NS = 40.0
) (
  // Control
  input wire logic en_in,
  input wire logic lvl_in,
  // Pin level
  output logic clk_out
);
  logic ck;

  // Stands still at low while disabled
  initial begin
    ck = 1'b0;
    forever #(HALF_NS) ck = en_in ? ~ck : 1'b0;
  end

  // Outside clock modes the pin carries a plain port level
  assign clk_out = en_in ? ck : lvl_in;
endmodule : osc_source_model

// File: testbench/oscillator_mode_and_internal_clock_test.sv
// Self-checking bench for the oscillator mode and internal clock block
`timescale 1ns/1ps
`include "osc_params.svh"
`define CHK(nm, e, g) begin total_checks++; if ((e) !== (g)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module oscillator_mode_and_internal_clock_test;
  import osc_pkg::*;
  logic clk, rst_b, wr, rd, t1, t1_en, en, lvl6, lvl7;
  logic [2:0] cfg;
  logic [3:0] t1c;
  slow_rc_users_t users;
  pin_drive_t p6, p7;
  logic [7:0] addr, wdata, rdata;
  logic in_o, in_oe, out_o, out_oe, b6_pin, b7_pin, b6_io, b7_io;
  logic sys, slow, run, sdly, src;
  logic [2:0] mode;
  wire osc_in_w = in_oe ? in_o : src;
  wire osc_out_w = out_oe ? out_o : lvl6;
  int n_mismatch = 0;
  int total_checks = 0;
  int n[4];
  // Modes where a pin belongs to the port, and crystal modes
  localparam logic [7:0] IO6 = 8'h58;
  localparam logic [7:0] IO7 = 8'h30;
  localparam logic [7:0] XTAL = 8'h07;

  osc_config #(.SETTLE_CYCLES(640)) osc_config_i (
    .MCLK_IN(clk), .RST_B_IN(rst_b), .CFG_MODE_IN(cfg), .SLOW_USERS_IN(users),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_RDATA_OUT(rdata), .OSC_IN_PIN_IN(osc_in_w), .OSC_IN_PIN_OUT(in_o),
    .OSC_IN_PIN_OE_OUT(in_oe), .OSC_OUT_PIN_IN(osc_out_w), .OSC_OUT_PIN_OUT(out_o),
    .OSC_OUT_PIN_OE_OUT(out_oe), .PORT_BIT6_IN(p6), .PORT_BIT7_IN(p7),
    .PORT_BIT6_PIN_OUT(b6_pin), .PORT_BIT7_PIN_OUT(b7_pin), .PORT_BIT6_IS_IO_OUT(b6_io),
    .PORT_BIT7_IS_IO_OUT(b7_io), .TIMER1_TICK_IN(t1), .SYSCLK_TICK_OUT(sys),
    .SLOW_RC_TICK_OUT(slow), .SLOW_RC_RUN_OUT(run), .STARTUP_DELAY_OUT(sdly),
    .MODE_OUT(mode)
  );

  osc_source_model osc_source_model_i (.en_in(en), .lvl_in(lvl7), .clk_out(src));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Secondary oscillator: one pulse every 16 cycles
  always @(posedge clk) begin
    t1c <= t1c + 4'h1;
    t1 <= t1_en && (t1c == 4'h0);
  end

  task automatic do_reset(input logic [2:0] m);
    @(posedge clk);
    cfg <= m;
    rst_b <= 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask : do_reset

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] msk, input logic [7:0] e,
                        input string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(nm, e, rdata & msk)
  endtask : rd_chk

  // Rising edges of system tick, slow tick, output pin and input pin
  task automatic cnt(input int cyc);
    logic [3:0] s;
    logic [3:0] p;
    p = 4'h0;
    n = '{0, 0, 0, 0};
    repeat (cyc) begin
      @(posedge clk);
      #1;
      s = {osc_in_w, osc_out_w, slow, sys};
      for (int i = 0; i < 4; i++) n[i] += int'(s[i] & ~p[i]);
      p = s;
    end
  endtask : cnt

  task automatic near(input string nm, input int got, input int e);
    `CHK(nm, 1'b1, (got >= e - 1) && (got <= e + 1))
  endtask : near

  task automatic t_regs;
    do_reset(INTERNAL_OSC_IO_MODE);
    rd_chk(`OSC_TRIM_ADDR, 8'hff, {2'h0, `OSC_TRIM_RESET}, "trim reset");
    wr_reg(`OSC_TRIM_ADDR, 8'hff);
    rd_chk(`OSC_TRIM_ADDR, 8'hff, 8'h3f, "trim upper bits");
    wr_reg(`OSC_TRIM_ADDR, 8'h20);
    rd_chk(`OSC_TRIM_ADDR, 8'hff, 8'h20, "trim minimum");
    wr_reg(8'h91, 8'h55);
    rd_chk(8'h91, 8'hff, 8'h00, "unmapped");
    wr_reg(`OSC_CTRL_ADDR, 8'hff);
    rd_chk(`OSC_CTRL_ADDR, 8'hff, 8'h7b, "control fields");
    wr_reg(`OSC_CTRL_ADDR, 8'h00);
    wr_reg(`OSC_TRIM_ADDR, 8'h00);
  endtask : t_regs

  task automatic t_modes;
    for (int m = 0; m < 8; m++) begin
      do_reset(3'(m));
      `CHK("mode", 3'(m), mode)
      `CHK("startup", XTAL[m], sdly)
      `CHK("bit6 io", IO6[m], b6_io)
      `CHK("bit7 io", IO7[m], b7_io)
      cfg <= ~3'(m);
      repeat (3) @(posedge clk);
      #1;
      `CHK("mode held", 3'(m), mode)
    end
  endtask : t_modes

  task automatic t_pins;
    do_reset(INTERNAL_OSC_IO_MODE);
    p6 <= 2'b11;
    p7 <= 2'b11;
    repeat (2) @(posedge clk);
    #1;
    `CHK("out pin drive", 2'b11, {out_o, out_oe})
    `CHK("in pin drive", 2'b11, {in_o, in_oe})
    p6 <= 2'b00;
    p7 <= 2'b00;
    lvl6 <= 1'b1;
    lvl7 <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    `CHK("port levels", 3'b011, {out_oe, b6_pin, b7_pin})
    lvl6 <= 1'b0;
    lvl7 <= 1'b0;
    do_reset(INTERNAL_OSC_CLKOUT_MODE);
    wr_reg(`OSC_CTRL_ADDR, 8'h70);
    cnt(4096);
    `CHK("clkout enable", 1'b1, out_oe)
    near("internal div4", n[2], exp_ticks(4096, 7, 0) / 4);
  endtask : t_pins

  task automatic t_ext;
    logic [2:0] ml[3];
    ml = '{EXTERNAL_CLOCK_IO_MODE, EXTERNAL_RC_MODE_CLKOUT, EXTERNAL_RC_MODE_IO};
    en <= 1'b1;
    foreach (ml[i]) begin
      do_reset(ml[i]);
      cnt(4096);
      near("ticks follow pin", n[0], n[3]);
      if (ml[i] == EXTERNAL_RC_MODE_CLKOUT) begin
        near("rc div4", n[2], n[3] / 4);
      end else begin
        `CHK("no clock out", 0, n[2])
      end
    end
    en <= 1'b0;
  endtask : t_ext

  function automatic int exp_ticks(input int w, input int k, input int t);
    return (w * 8 * (256 + t) / 32000) >> (7 - k);
  endfunction : exp_ticks

  task automatic t_freq;
    int w;
    do_reset(INTERNAL_OSC_IO_MODE);
    for (int k = 0; k < 8; k++) begin
      w = (k == 0) ? 16384 : 4096;
      wr_reg(`OSC_CTRL_ADDR, {1'b0, 3'(k), 4'h2});
      repeat (4) @(posedge clk);
      cnt(w);
      if (k == 0) begin
        near("slow sysclk", n[0], w / 4000);
        near("slow tick", n[1], w / 4000);
      end else begin
        near("fast sysclk", n[0], exp_ticks(w, k, 0));
      end
    end
    wr_reg(`OSC_TRIM_ADDR, 8'h1f);
    repeat (700) @(posedge clk);
    cnt(4096);
    near("trim maximum", n[0], exp_ticks(4096, 7, 31));
    wr_reg(`OSC_TRIM_ADDR, 8'h20);
    repeat (700) @(posedge clk);
    cnt(4096);
    near("trim minimum", n[0], exp_ticks(4096, 7, -32));
  endtask : t_freq

  task automatic t_src;
    do_reset(INTERNAL_OSC_IO_MODE);
    t1_en <= 1'b1;
    wr_reg(`OSC_CTRL_ADDR, 8'h71);
    repeat (4) @(posedge clk);
    cnt(4096);
    near("timer1 sysclk", n[0], 256);
    t1_en <= 1'b0;
    do_reset(LOW_POWER_CRYSTAL_MODE);
    `CHK("slow idle", 1'b0, run)
    for (int i = 0; i < 4; i++) begin
      users <= 4'(1 << i);
      repeat (3) @(posedge clk);
      #1;
      `CHK("slow user", 1'b1, run)
    end
    users <= 4'h0;
    wr_reg(`OSC_CTRL_ADDR, 8'h02);
    repeat (3) @(posedge clk);
    #1;
    `CHK("slow selected", 1'b1, run)
    rd_chk(`OSC_CTRL_ADDR, 8'hff, 8'h02, "internal status");
    do_reset(INTERNAL_OSC_IO_MODE);
    `CHK("slow primary", 1'b1, run)
  endtask : t_src

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    {rst_b, wr, rd, t1_en, en, lvl6, lvl7, t1, t1c} = '0;
    {cfg, addr, wdata, p6, p7, users} = '0;
    t_regs();
    t_modes();
    t_pins();
    t_ext();
    t_freq();
    t_src();
    print_verdict();
  end

  initial begin
    #760000;
    n_mismatch++;
    print_verdict();
  end
endmodule : oscillator_mode_and_internal_clock_test
